// ==== dv/fsp_far_model.sv ====
`default_nettype none
// ----------------------------------------
// stand-in for the oscillator and array programmer
// ----------------------------------------
module fsp_far_model
(
    input  wire logic [22:0] op_addr,
    output logic             osc_out,
    output logic [5:0]       rd_idx
);
    timeunit 1ns;
    timeprecision 1ps;
    // free-running and unrelated in phase to clk, so the synchroniser is exercised
    initial osc_out = 1'b0;
    always #7.3 osc_out = ~osc_out;
    // the programmer reads the entry that the operation address names
    assign rd_idx = op_addr[5:0];
endmodule // fsp_far_model
`default_nettype wire

// ==== dv/test_flash_self_program_sequencer.sv ====
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_flash_self_program_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;
    typedef struct packed {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} fsp_row_t;
    logic clk, srst, rd, wr, osc, busy, start;
    logic [4:0]  adr;
    logic [31:0] wdat, rdo, rdat;
    logic        wt;
    logic [5:0]  idx;
    logic [23:0] word;
    logic [22:0] op_addr;
    fsp_op_t     kind;
    int          err_total, checks_done;
    int          n_start = 0;
    // reset checks, unmapped place, refused start, unlock and its cancelling
    fsp_row_t rows [17] = '{'{0, OFF_CTRL, 0, 0}, '{0, OFF_STAT, 0, 0}, '{0, OFF_KEY, 0, 0},
        '{0, 5'h18, 0, 0}, '{1, 5'h18, 32'hFFFF_FFFF, 0}, '{0, OFF_PTR, 0, 0},
        '{1, OFF_PTR, 32'h41, 0}, '{0, OFF_PTR, 0, 32'h41}, '{1, OFF_CTRL, 32'h8001, 0},
        '{0, OFF_STAT, 0, 32'h4}, '{1, OFF_STAT, 32'h4, 0}, '{0, OFF_STAT, 0, 0},
        '{1, OFF_KEY, 32'h55, 0}, '{1, OFF_KEY, 32'hAA, 0}, '{0, OFF_STAT, 0, 32'h2},
        '{1, 5'h18, 0, 0}, '{0, OFF_STAT, 0, 0}};
    fsp_flash_seq #(.ROW_FRC_CYC(4), .WORD_FRC_CYC(4), .PAGE_FRC_CYC(4)) fsp_flash_seq_i (
        .clk(clk), .srst(srst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdo),
        .avs_waitrequest(wt), .frc_osc_in(osc), .flash_rd_idx(idx), .flash_rd_data(word),
        .flash_op_busy(busy), .flash_op_start(start), .flash_op_kind(kind),
        .flash_op_addr(op_addr));
    fsp_far_model fsp_far_model_i (.op_addr(op_addr), .osc_out(osc), .rd_idx(idx));
    // the start pulse lasts one cycle, so it is counted at every edge rather than peeked at
    always @(posedge clk)
        if (start === 1'b1)
            n_start <= n_start + 1;
    // ----------------------------------------
    // bus and report tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // request held until waitrequest is seen low; a stall longer than the bound is a hang
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        for (k = 0; k < 4000; k++)
        begin
            @(posedge clk);
            if (wt === 1'b0)
                break;
        end
        rdat = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k == 4000)
        begin
            err_total++;
            end_sim();
        end
        @(posedge clk);
    endtask
    // fill the buffer from a pointer, unlock, start, then stall behind the operation
    task automatic run_op(input fsp_op_t op, input logic [22:0] p, input logic [22:0] ea,
                          input logic [23:0] ew);
        int k;
        int s0;
        realtime t0;
        bus(1, OFF_PTR, {9'h0, p});
        for (k = 0; k < ROW_INSTR; k++)
        begin
            bus(1, OFF_TWL, 32'(k));
            bus(1, OFF_TWH, 32'(k[7:0]));
        end
        bus(0, OFF_STAT, 0);
        `CHK("fill", 32'(FILL_MAX) << STAT_FILL_LSB, rdat)
        bus(1, OFF_KEY, 32'(KEY_FIRST));
        bus(1, OFF_KEY, 32'(KEY_SECOND));
        s0 = n_start;
        bus(1, OFF_CTRL, 32'h8000 | 32'(op));
        t0 = $realtime;
        `CHK("kind", op, kind)
        `CHK("addr", ea, op_addr)
        @(posedge clk);
        `CHK("start", 2'b11, {n_start == s0 + 1, busy})
        `CHK("word", ew, word)
        `CHK("held", op, kind)
        bus(0, OFF_STAT, 0);
        `CHK("stall", 1'b1, ($realtime - t0) >= 40.0)
        `CHK("stat", 0, rdat)
        `CHK("busy", 1'b0, busy)
        bus(0, OFF_CTRL, 0);
        `CHK("ctrl", 32'(op), rdat)
        $display("test op %0d done", op);
    endtask
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {srst, rd, wr, adr, wdat, err_total, checks_done} = {3'b100, 37'h0, 64'h0};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("rst busy", 2'b00, {busy, start})
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                `CHK("reg", rows[i].e, rdat)
        end
        `CHK("no start", 2'b00, {n_start != 0, busy})
        $display("test register rows done");
        run_op(OP_ROW, 23'h41, 23'h40, 24'h3F_003F);
        run_op(OP_WORD, 23'h05, 23'h05, 24'h00_0000);
        run_op(OP_PAGE, 23'h3FF, 23'h200, 24'h01_0001);
        // reset in the middle of an operation must drop it and free the bus
        bus(1, OFF_KEY, 32'(KEY_FIRST));
        bus(1, OFF_KEY, 32'(KEY_SECOND));
        bus(1, OFF_CTRL, 32'h8001);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("rst op", 3'b000, {busy, start, kind != OP_NONE})
        bus(0, OFF_CTRL, 0);
        `CHK("rst ctrl", 0, rdat)
        $display("test reset done");
        end_sim();
    end
endmodule // test_flash_self_program_sequencer
`default_nettype wire

// ==== hw/fsp_flash_seq.sv ====
// Our own choices: the address map and the Avalon-MM slave port.
`default_nettype none
// ------------------------------------------------------------
// ------------------------------------------------------------
module fsp_flash_seq
#(
    parameter int ROW_FRC_CYC  = fsp_pkg::ROW_WRITE_FRC_CYC,
    parameter int WORD_FRC_CYC = fsp_pkg::WORD_WRITE_FRC_CYC,
    parameter int PAGE_FRC_CYC = fsp_pkg::PAGE_ERASE_FRC_CYC
)
(
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic [fsp_pkg::AV_ADDR_W-1:0] avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic                          frc_osc_in,
    input  wire logic [fsp_pkg::IDX_W-1:0]     flash_rd_idx,
    output logic      [fsp_pkg::WORD_W-1:0]    flash_rd_data,
    output logic                               flash_op_busy,
    output logic                               flash_op_start,
    output fsp_pkg::fsp_op_t                   flash_op_kind,
    output logic      [fsp_pkg::ADDR_W-1:0]    flash_op_addr
);
    import fsp_pkg::*;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [REG_N-1:0] reg_sel(input logic [AV_ADDR_W-1:0] a);
        logic [REG_N-1:0] s;
        s = '0;
        case (a)
            OFF_CTRL: s[RI_CTRL] = 1'b1;
            OFF_KEY:  s[RI_KEY]  = 1'b1;
            OFF_PTR:  s[RI_PTR]  = 1'b1;
            OFF_TWL:  s[RI_TWL]  = 1'b1;
            OFF_TWH:  s[RI_TWH]  = 1'b1;
            OFF_STAT: s[RI_STAT] = 1'b1;
            default:  s = '0;
        endcase
        return s;
    endfunction

    // byte lanes left off keep the old contents
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return (old & ~m) | (wd & m);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    fsp_core_if         core ();
    fsp_state_t         st_r;
    fsp_key_t           key_r;
    fsp_op_t            ctrl_op_r;
    fsp_op_t            op_kind_r;
    fsp_op_t            op_new;
    logic               ctrl_start_r;
    logic               busy_r;
    logic               phase_r;
    logic               key_err_r;
    logic               start_pulse_r;
    logic [ADDR_W-1:0]  ptr_r;
    logic [ADDR_W-1:0]  op_addr_r;
    logic [IDX_W-1:0]   fill_idx_r;
    logic [6:0]         fill_cnt_r;
    logic [LO_W-1:0]    lo_stage_r;
    logic [31:0]        rdata_r;
    logic [31:0]        rd_mux;
    logic [31:0]        ctrl_rd;
    logic [31:0]        ctrl_new;
    logic [REG_N-1:0]   sel;
    logic               req;
    logic               accept;
    logic               wr_acc;
    logic               start_req;
    logic               start_go;
    logic               key_bad;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    // every access takes one wait cycle so read data come from a flop;
    // while busy the answer is held back, which stalls the processor
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = busy_r | ~phase_r;
    assign accept          = req & ~avs_waitrequest;
    assign wr_acc          = accept & avs_write;
    assign sel             = reg_sel(avs_address);
    assign avs_readdata    = rdata_r;

    // first cycle of an access arms the answer for the next edge
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            phase_r <= 1'b0;
        end
        else if (accept)
        begin
            phase_r <= 1'b0;
        end
        else if (req && !busy_r)
        begin
            phase_r <= 1'b1;
        end
    end

    // read multiplexer; the key register reads as zero
    always_comb
    begin
        ctrl_rd                               = '0;
        ctrl_rd[CTRL_START_BIT]               = ctrl_start_r;
        ctrl_rd[CTRL_OP_LSB +: 2]             = ctrl_op_r;
        rd_mux                                = '0;
        if (sel[RI_CTRL])
        begin
            rd_mux = ctrl_rd;
        end
        else if (sel[RI_PTR])
        begin
            rd_mux[ADDR_W-1:0] = ptr_r;
        end
        else if (sel[RI_STAT])
        begin
            rd_mux[STAT_BUSY_BIT]         = busy_r;
            rd_mux[STAT_ARMED_BIT]        = (key_r == KS_ARMED);
            rd_mux[STAT_KEYERR_BIT]       = key_err_r;
            rd_mux[STAT_FILL_LSB +: 7]    = fill_cnt_r;
        end
    end

    // read data captured during the wait cycle, standing until the next
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata_r <= '0;
        end
        else if (avs_read && !phase_r && !busy_r)
        begin
            rdata_r <= rd_mux;
        end
    end

    // ----------------------------------------
    // control register and start qualification
    // ----------------------------------------
    assign ctrl_new  = be_merge(ctrl_rd, avs_writedata, avs_byteenable);
    assign op_new    = fsp_op_t'(ctrl_new[CTRL_OP_LSB +: 2]);
    assign start_req = wr_acc & sel[RI_CTRL] & ctrl_new[CTRL_START_BIT];
    assign start_go  = start_req & (key_r == KS_ARMED) & (op_new != OP_NONE);
    assign key_bad   = start_req & (key_r != KS_ARMED);

    // operation select only moves between operations
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_op_r <= OP_NONE;
        end
        else if (wr_acc && sel[RI_CTRL] && !busy_r)
        begin
            ctrl_op_r <= op_new;
        end
    end

    // start bit: set by a qualified start, cleared by hardware at the end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_start_r <= 1'b0;
        end
        else if (start_go)
        begin
            ctrl_start_r <= 1'b1;
        end
        else if (st_r == ST_FIN)
        begin
            ctrl_start_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // unlock sequence
    // ----------------------------------------
    // any other write, the start write included, drops the unlock
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            key_r <= KS_NONE;
        end
        else if (wr_acc)
        begin
            if (sel[RI_KEY] && avs_byteenable[0])
            begin
                case (key_r)
                    KS_HALF:
                    begin
                        key_r <= (avs_writedata[7:0] == KEY_SECOND) ? KS_ARMED :
                                 (avs_writedata[7:0] == KEY_FIRST) ? KS_HALF : KS_NONE;
                    end
                    default:
                    begin
                        key_r <= (avs_writedata[7:0] == KEY_FIRST) ? KS_HALF : KS_NONE;
                    end
                endcase
            end
            else
            begin
                key_r <= KS_NONE;
            end
        end
    end

    // refused start is sticky; write one to clear, a new refusal wins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            key_err_r <= 1'b0;
        end
        else if (key_bad)
        begin
            key_err_r <= 1'b1;
        end
        else if (wr_acc && sel[RI_STAT] && avs_byteenable[0] &&
                 avs_writedata[STAT_KEYERR_BIT])
        begin
            key_err_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // table pointer and buffer fill
    // ----------------------------------------
    // writing the pointer restarts the fill at its row offset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ptr_r      <= PTR_RST;
            fill_idx_r <= '0;
            fill_cnt_r <= '0;
            lo_stage_r <= '0;
        end
        else if (st_r == ST_FIN)
        begin
            fill_cnt_r <= '0;
        end
        else if (wr_acc && sel[RI_PTR])
        begin
            ptr_r      <= ADDR_W'(be_merge(32'(ptr_r), avs_writedata, avs_byteenable));
            fill_idx_r <= avs_writedata[IDX_W-1:0];
            fill_cnt_r <= '0;
        end
        else if (wr_acc && sel[RI_TWL])
        begin
            lo_stage_r <= avs_writedata[LO_W-1:0];
        end
        else if (wr_acc && sel[RI_TWH])
        begin
            fill_idx_r <= fill_idx_r + IDX_W'(1);
            if (fill_cnt_r != FILL_MAX)
            begin
                fill_cnt_r <= fill_cnt_r + 7'(1);
            end
        end
    end

    // high-half write commits the staged word; wraps within one row
    assign core.wr_en   = wr_acc & sel[RI_TWH];
    assign core.wr_idx  = fill_idx_r;
    assign core.wr_data = {avs_writedata[HI_W-1:0], lo_stage_r};
    assign core.rd_idx  = flash_rd_idx;
    assign flash_rd_data = core.rd_data;

    fsp_hold_buf #(
        .DEPTH (ROW_INSTR)
    ) u_hold_buf (
        .clk  (clk),
        .core (core)
    );

    // ----------------------------------------
    // operation sequencer
    // ----------------------------------------
    assign core.tmr_start = start_go;
    assign core.tmr_limit = (op_new == OP_ROW)  ? CNT_W'(ROW_FRC_CYC) :
                            (op_new == OP_PAGE) ? CNT_W'(PAGE_FRC_CYC) :
                                                  CNT_W'(WORD_FRC_CYC);

    fsp_frc_timer u_frc_timer (
        .clk        (clk),
        .srst       (srst),
        .frc_osc_in (frc_osc_in),
        .core       (core)
    );

    // idle, run on the oscillator count, one finishing cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r <= ST_IDLE;
        end
        else
        begin
            case (st_r)
                ST_IDLE: st_r <= start_go ? ST_RUN : ST_IDLE;
                ST_RUN:  st_r <= core.tmr_done ? ST_FIN : ST_RUN;
                ST_FIN:  st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // busy covers the whole operation so the processor stays stalled
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busy_r <= 1'b0;
        end
        else if (start_go)
        begin
            busy_r <= 1'b1;
        end
        else if (st_r == ST_FIN)
        begin
            busy_r <= 1'b0;
        end
    end

    // target latched at start; row and page targets aligned to their boundary, a word target kept as is
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            op_kind_r     <= OP_NONE;
            op_addr_r     <= '0;
            start_pulse_r <= 1'b0;
        end
        else
        begin
            start_pulse_r <= start_go;
            if (start_go)
            begin
                op_kind_r <= op_new;
                case (op_new)
                    OP_ROW:  op_addr_r <= ptr_r & ~ADDR_W'(ROW_INSTR - 1);
                    OP_PAGE: op_addr_r <= ptr_r & ~ADDR_W'(PAGE_INSTR - 1);
                    default: op_addr_r <= ptr_r;
                endcase
            end
        end
    end

    assign flash_op_busy  = busy_r;
    assign flash_op_start = start_pulse_r;
    assign flash_op_kind  = op_kind_r;
    assign flash_op_addr  = op_addr_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_row_align;
        flash_op_start && flash_op_kind == OP_ROW |-> flash_op_addr[5:0] == 6'h00;
    endproperty
    a_row_align: assert property (p_row_align)
        else $error("row target not on a row boundary");

    property p_page_align;
        flash_op_start && flash_op_kind == OP_PAGE |-> flash_op_addr[8:0] == 9'h000;
    endproperty
    a_page_align: assert property (p_page_align)
        else $error("page target not on a page boundary");

    property p_tw_two;
        avs_write && sel[RI_TWH] && !phase_r && !busy_r
        |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_tw_two: assert property (p_tw_two)
        else $error("table write did not finish in two cycles");

    property p_stall;
        busy_r |-> avs_waitrequest throughout (busy_r [*1]);
    endproperty
    a_stall: assert property (p_stall)
        else $error("bus answered during an operation");

    property p_start_clear;
        st_r == ST_FIN |=> !ctrl_start_r && !busy_r;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start bit not cleared at the end");

    property p_needs_key;
        $rose(busy_r) |-> $past(key_r) == KS_ARMED;
    endproperty
    a_needs_key: assert property (p_needs_key)
        else $error("operation started without unlock");

    property p_op_stable;
        busy_r ##1 busy_r |-> $stable(flash_op_kind) && $stable(flash_op_addr);
    endproperty
    a_op_stable: assert property (p_op_stable)
        else $error("operation select moved while busy");

    property p_key_seq;
        wr_acc && sel[RI_KEY] && avs_byteenable[0] && key_r == KS_HALF &&
        avs_writedata[7:0] == KEY_SECOND |=> key_r == KS_ARMED;
    endproperty
    a_key_seq: assert property (p_key_seq)
        else $error("second key byte did not unlock");

    property p_fill_seq;
        wr_acc && sel[RI_TWH] |=> fill_idx_r == $past(fill_idx_r) + IDX_W'(1);
    endproperty
    a_fill_seq: assert property (p_fill_seq)
        else $error("holding buffer not filled in sequence");

    c_row:  cover property (flash_op_start && flash_op_kind == OP_ROW);
    c_page: cover property (flash_op_start && flash_op_kind == OP_PAGE);
    c_word: cover property (flash_op_start && flash_op_kind == OP_WORD);
    c_bad:  cover property (key_bad);
endmodule // fsp_flash_seq
`default_nettype wire

// ==== hw/fsp_frc_timer.sv ====
`default_nettype none
module fsp_frc_timer
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic frc_osc_in,
    fsp_core_if.tmr   core
);
    import fsp_pkg::*;
    // ----------------------------------------
    // oscillator synchroniser and edge detect
    // ----------------------------------------
    logic             sync1_r;
    logic             sync2_r;
    logic             sync3_r;
    logic             frc_rise;
    logic             run_r;
    logic             done_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] limit_r;

    // two flops before anything looks at the pin
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end
        else
        begin
            sync1_r <= frc_osc_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    assign frc_rise = sync2_r & ~sync3_r;

    // ----------------------------------------
    // cycle counter
    // ----------------------------------------
    // duration follows the oscillator, not clk, so tuning shifts it
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            run_r   <= 1'b0;
            done_r  <= 1'b0;
            cnt_r   <= '0;
            limit_r <= '0;
        end
        else
        begin
            done_r <= 1'b0;
            if (core.tmr_start)
            begin
                run_r   <= 1'b1;
                cnt_r   <= '0;
                limit_r <= core.tmr_limit;
            end
            else if (run_r && frc_rise)
            begin
                if (cnt_r == limit_r - CNT_W'(1))
                begin
                    run_r  <= 1'b0;
                    done_r <= 1'b1;
                end
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end
    assign core.tmr_done = done_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_frc_count;
        @(posedge clk) disable iff (srst)
        (run_r && frc_rise && !core.tmr_start && cnt_r == limit_r - CNT_W'(1))
        |=> (done_r && !run_r);
    endproperty
    a_frc_count: assert property (p_frc_count)
        else $error("timer did not end on the last oscillator cycle");
endmodule // fsp_frc_timer
`default_nettype wire

// ==== hw/fsp_hold_buf.sv ====
`default_nettype none
module fsp_hold_buf
#(
    parameter int DEPTH = fsp_pkg::ROW_INSTR
)
(
    input  wire logic clk,
    fsp_core_if.hb    core
);
    import fsp_pkg::*;
    // ----------------------------------------
    // holding buffer, one row of instructions
    // ----------------------------------------
    logic [WORD_W-1:0] mem [DEPTH];

    // data words carry no reset; software refills before each row
    always_ff @(posedge clk)
    begin
        if (core.wr_en)
        begin
            mem[core.wr_idx] <= core.wr_data;
        end
    end

    // registered read port toward the array programmer
    always_ff @(posedge clk)
    begin
        core.rd_data <= mem[core.rd_idx];
    end
endmodule // fsp_hold_buf
`default_nettype wire

// ==== inc/fsp_core_if.sv ====
`default_nettype none
interface fsp_core_if;
    import fsp_pkg::*;
    logic               wr_en;
    logic [IDX_W-1:0]   wr_idx;
    logic [WORD_W-1:0]  wr_data;
    logic [IDX_W-1:0]   rd_idx;
    logic [WORD_W-1:0]  rd_data;
    logic               tmr_start;
    logic [CNT_W-1:0]   tmr_limit;
    logic               tmr_done;
    modport ctl (output wr_en, wr_idx, wr_data, rd_idx, tmr_start, tmr_limit,
                 input rd_data, tmr_done);
    modport hb (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
    modport tmr (input tmr_start, tmr_limit, output tmr_done);
endinterface
`default_nettype wire

// ==== inc/fsp_pkg.sv ====
`default_nettype none
package fsp_pkg;
    // ----------------------------------------
    // register map, byte offsets on the bus
    // ----------------------------------------
    localparam int              AV_ADDR_W = 5;
    localparam int              REG_N     = 6;
    localparam int              RI_CTRL   = 0;
    localparam int              RI_KEY    = 1;
    localparam int              RI_PTR    = 2;
    localparam int              RI_TWL    = 3;
    localparam int              RI_TWH    = 4;
    localparam int              RI_STAT   = 5;
    localparam logic [4:0]      OFF_CTRL  = 5'h00;
    localparam logic [4:0]      OFF_KEY   = 5'h04;
    localparam logic [4:0]      OFF_PTR   = 5'h08;
    localparam logic [4:0]      OFF_TWL   = 5'h0C;
    localparam logic [4:0]      OFF_TWH   = 5'h10;
    localparam logic [4:0]      OFF_STAT  = 5'h14;
    // field positions and reset values
    localparam int              CTRL_START_BIT  = 15;
    localparam int              CTRL_OP_LSB     = 0;
    localparam int              STAT_BUSY_BIT   = 0;
    localparam int              STAT_ARMED_BIT  = 1;
    localparam int              STAT_KEYERR_BIT = 2;
    localparam int              STAT_FILL_LSB   = 8;
    localparam logic [22:0]     PTR_RST         = 23'h00_0000;
    localparam logic [7:0]      KEY_FIRST       = 8'h55;
    localparam logic [7:0]      KEY_SECOND      = 8'hAA;
    // ----------------------------------------
    // flash geometry and timing
    // ----------------------------------------
    localparam int              ADDR_W      = 23;
    localparam int              WORD_W      = 24;
    localparam int              LO_W        = 16;
    localparam int              HI_W        = WORD_W - LO_W;
    localparam int              IDX_W       = 6;
    localparam int              ROW_INSTR   = 64;
    localparam int              PAGE_ROWS   = 8;
    localparam int              PAGE_INSTR  = ROW_INSTR * PAGE_ROWS;
    localparam int              INSTR_BYTES = 3;
    localparam int              ROW_BYTES   = ROW_INSTR * INSTR_BYTES;
    localparam int              PAGE_BYTES  = PAGE_INSTR * INSTR_BYTES;
    localparam logic [6:0]      FILL_MAX    = 7'h40;
    localparam int              CNT_W       = 18;
    localparam int              ROW_WRITE_FRC_CYC  = 168517;
    localparam int              WORD_WRITE_FRC_CYC = 168517;
    localparam int              PAGE_ERASE_FRC_CYC = 168517;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_ROW  = 2'b01,
        OP_WORD = 2'b10,
        OP_PAGE = 2'b11
    } fsp_op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_FIN  = 3'b100
    } fsp_state_t;
    typedef enum logic [2:0] {
        KS_NONE  = 3'b001,
        KS_HALF  = 3'b010,
        KS_ARMED = 3'b100
    } fsp_key_t;
endpackage
`default_nettype wire
